// file: verilog/pst_consts.vh
// constants for the ptp system time and timestamp block
// Function
// - keep 64-bit time, stamp frames with it
// - time runs on selected reference clock
// - coarse init loads counter from update value
// - coarse correction adds or subtracts offset once
// - addend accumulates, carry increments time counter
// - accumulator and addend are 32 bits
// - each increment adds sub-second constant 43
// - stamp every received frame into descriptor, except one that starts inside the snapshot gap or has its last descriptor in its start cycle
// - stamp transmit frame at start delimiter
// - 43 nanosecond step in every mode
// - provide pulse-per-second from system time
// - skip snapshot inside four phy plus three ref
// - receive stamp only in last descriptor
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH
`define PST_TIME_W        64
`define PST_ACC_W         32
`define PST_SUBSEC_INC    32'h0000002B
`define PST_SUBSEC_ROLL   32'h3B9ACA00
`define PST_ADDEND_RST    32'h00000000
`define PST_GAP_PHY       4
`define PST_GAP_REF       3
`define PST_GAP_CYCLES    (`PST_GAP_PHY + `PST_GAP_REF)
`define PST_PPS_NS        32'h05F5E100
`endif

// file: verilog/pst_snapshot.v
// one timestamp capture channel with minimum spacing between snapshots
`timescale 1ns/1ps
`default_nettype none
`include "pst_consts.vh"
module pst_snapshot (
  input  wire        clock,
  input  wire        rst,
  input  wire        sof,
  input  wire        want,
  input  wire        last_desc,
  input  wire [63:0] now,
  output reg  [63:0] stamp_reg,
  output reg         stamp_valid_reg,
  output reg         stamp_skip_reg
);
  reg [3:0] gap_reg;
  reg       pend_reg;
  reg       armed_reg;
  wire      busy = (gap_reg != 4'h0);
  // spacing count kept 32 bits wide, then cut to the counter width on purpose
  localparam integer GAP_LOAD = `PST_GAP_CYCLES;
  wire [31:0] gap_load_w = GAP_LOAD;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_reg         <= 4'h0;
      pend_reg        <= 1'b0;
      armed_reg       <= 1'b0;
      stamp_reg       <= 64'h0000000000000000;
      stamp_valid_reg <= 1'b0;
      stamp_skip_reg  <= 1'b0;
    end else begin
      stamp_valid_reg <= 1'b0;
      stamp_skip_reg  <= 1'b0;
      if (busy)
        gap_reg <= gap_reg - 4'h1;
      if (sof && want) begin
        if (busy) begin
          stamp_skip_reg <= 1'b1;
        end else begin
          stamp_reg <= now;
          armed_reg <= 1'b1;
          gap_reg   <= gap_load_w[3:0];
        end
      end
      // stamp is delivered only with the frame's last descriptor
      if (last_desc && (armed_reg || (sof && want && !busy))) begin
        pend_reg <= 1'b0;
      end
      if (last_desc && armed_reg) begin
        stamp_valid_reg <= 1'b1;
        armed_reg       <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/pst_system_time.v
// ptp system time counter with coarse and fine correction and frame stamps
`timescale 1ns/1ps
`default_nettype none
`include "pst_consts.vh"
module pst_system_time (
  input  wire        clock,
  input  wire        rst,
  input  wire        use_fabric_ref,
  input  wire        hps_ref_tick,
  input  wire        fabric_ptp_reference_clock,
  input  wire        fine_mode,
  input  wire        init_strobe,
  input  wire        offset_strobe,
  input  wire        offset_subtract,
  input  wire [31:0] update_seconds,
  input  wire [31:0] update_subseconds,
  input  wire        addend_write,
  input  wire [31:0] addend_value,
  input  wire        rx_sof,
  input  wire        rx_last_desc,
  input  wire        tx_sof,
  input  wire        tx_want_stamp,
  input  wire        tx_last_desc,
  output reg  [63:0] system_time_reg,
  output wire [63:0] rx_stamp,
  output wire        rx_stamp_valid,
  output wire        rx_stamp_skip,
  output wire [63:0] tx_stamp,
  output wire        tx_stamp_valid,
  output wire        tx_stamp_skip,
  output reg         pps_reg
);
  // ------------------------------------------------------------
  // reference tick select
  // ------------------------------------------------------------
  // reference clocks arrive as tick levels sampled on clock
  reg  fab_q_reg;
  reg  hps_q_reg;
  wire ref_tick = use_fabric_ref ? (fabric_ptp_reference_clock & ~fab_q_reg)
                                 : (hps_ref_tick & ~hps_q_reg);

  // ------------------------------------------------------------
  // fine accumulator
  // ------------------------------------------------------------
  reg  [31:0] addend_reg;
  reg  [31:0] acc_reg;
  wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, addend_reg};
  wire        inc_pulse = fine_mode ? (ref_tick & acc_sum[32]) : ref_tick;

  wire [31:0] sec  = system_time_reg[63:32];
  wire [31:0] sub  = system_time_reg[31:0];
  wire [32:0] sub_inc = {1'b0, sub} + {1'b0, `PST_SUBSEC_INC};
  wire        roll_inc = (sub_inc >= {1'b0, `PST_SUBSEC_ROLL});
  wire [32:0] inc_wrapped = sub_inc - {1'b0, `PST_SUBSEC_ROLL};

  // coarse offset arithmetic with sub-second wrap
  wire [32:0] sub_add = {1'b0, sub} + {1'b0, update_subseconds};
  wire        add_wrap = (sub_add >= {1'b0, `PST_SUBSEC_ROLL});
  wire [32:0] add_wrapped = sub_add - {1'b0, `PST_SUBSEC_ROLL};
  wire        sub_borrow = (sub < update_subseconds);

  reg  [63:0] time_next;
  always @* begin
    time_next = system_time_reg;
    if (init_strobe) begin
      time_next = {update_seconds, update_subseconds};
    end else if (offset_strobe) begin
      if (offset_subtract) begin
        time_next[31:0]  = sub_borrow ? (sub + `PST_SUBSEC_ROLL - update_subseconds)
                                      : (sub - update_subseconds);
        time_next[63:32] = sec - update_seconds - {31'h0, sub_borrow};
      end else begin
        time_next[31:0]  = add_wrap ? add_wrapped[31:0]
                                    : sub_add[31:0];
        time_next[63:32] = sec + update_seconds + {31'h0, add_wrap};
      end
    end else if (inc_pulse) begin
      time_next[31:0]  = roll_inc ? inc_wrapped[31:0]
                                  : sub_inc[31:0];
      time_next[63:32] = sec + {31'h0, roll_inc};
    end
  end

  // ------------------------------------------------------------
  // counter, accumulator and pps
  // ------------------------------------------------------------
  reg [31:0] pps_cnt_reg;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fab_q_reg       <= 1'b0;
      hps_q_reg       <= 1'b0;
      addend_reg      <= `PST_ADDEND_RST;
      acc_reg         <= 32'h00000000;
      system_time_reg <= 64'h0000000000000000;
      pps_reg         <= 1'b0;
      pps_cnt_reg     <= 32'h00000000;
    end else begin
      fab_q_reg <= fabric_ptp_reference_clock;
      hps_q_reg <= hps_ref_tick;
      // new addend used from the next tick; acc and time untouched
      if (addend_write)
        addend_reg <= addend_value;
      if (ref_tick && fine_mode)
        acc_reg <= acc_sum[31:0];
      system_time_reg <= time_next;
      // pps high for the first half second of each second
      pps_reg <= (time_next[31:0] < (`PST_SUBSEC_ROLL >> 1));
      pps_cnt_reg <= time_next[63:32];
    end
  end

  // ------------------------------------------------------------
  // frame snapshots
  // ------------------------------------------------------------
  pst_snapshot u_rx (
    .clock           (clock),
    .rst             (rst),
    .sof             (rx_sof),
    .want            (1'b1),
    .last_desc       (rx_last_desc),
    .now             (system_time_reg),
    .stamp_reg       (rx_stamp),
    .stamp_valid_reg (rx_stamp_valid),
    .stamp_skip_reg  (rx_stamp_skip)
  );

  pst_snapshot u_tx (
    .clock           (clock),
    .rst             (rst),
    .sof             (tx_sof),
    .want            (tx_want_stamp),
    .last_desc       (tx_last_desc),
    .now             (system_time_reg),
    .stamp_reg       (tx_stamp),
    .stamp_valid_reg (tx_stamp_valid),
    .stamp_skip_reg  (tx_stamp_skip)
  );
endmodule
`default_nettype wire

// file: tb/pst_checker_assertions.sv
// assertions on the ports of the ptp system time block
`timescale 1ns/1ps
`default_nettype none
module pst_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        init_strobe,
  input wire logic [31:0] update_seconds,
  input wire logic [31:0] update_subseconds,
  input wire logic        rx_sof,
  input wire logic        rx_last_desc,
  input wire logic [63:0] system_time_reg,
  input wire logic [63:0] rx_stamp,
  input wire logic        rx_stamp_valid,
  input wire logic        rx_stamp_skip
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_init_load: assert property (init_strobe |=>
    system_time_reg == {$past(update_seconds), $past(update_subseconds)}) else $error("no load");
  a_ns_range: assert property (system_time_reg[31:0] < 32'h3B9ACA00)
    else $error("ns range");
  a_rx_value: assert property ($changed(rx_stamp) |-> $past(rx_sof)
    && rx_stamp == $past(system_time_reg)) else $error("rx stamp");
  a_valid_last: assert property (rx_stamp_valid |-> $past(rx_last_desc))
    else $error("valid early");
  a_valid_once: assert property (rx_stamp_valid |=> !rx_stamp_valid)
    else $error("valid long");
  a_skip_keep: assert property (rx_stamp_skip |-> $stable(rx_stamp))
    else $error("skip stamped");
  a_gap_skip: assert property (rx_sof ##1 rx_sof |-> ##[0:2] rx_stamp_skip)
    else $error("no skip");
  a_skip_alone: assert property (rx_stamp_skip |-> !rx_stamp_valid)
    else $error("skip and valid");
endmodule
bind pst_system_time pst_checker pst_checker_inst (.*);
`default_nettype wire

// file: tb/pst_ref_source.sv
// reference tick source for the processor and fabric inputs
`timescale 1ns/1ps
`default_nettype none
module pst_ref_source (
  input  wire logic clock,
  input  wire logic run,
  input  wire logic pick_fabric,
  output wire logic fabric_ptp_reference_clock,
  output wire logic hps_ref_tick
);
  logic [1:0] phase_reg = 2'h0;
  // unpicked line stays low, one tick per four cycles
  always @(negedge clock) phase_reg <= run ? phase_reg + 2'h1 : 2'h0;
  assign fabric_ptp_reference_clock = pick_fabric & phase_reg[1];
  assign hps_ref_tick = !pick_fabric & phase_reg[1];
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the ptp system time block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t %h %h", $time, g, e); end end
module tb_top;
  logic clock = 0, rst = 1, use_fabric_ref = 0, pick_fabric = 0, fine_mode = 0, run = 0;
  logic init_strobe = 0, offset_strobe = 0, offset_subtract = 0, addend_write = 0;
  logic rx_sof = 0, rx_last_desc = 0, tx_sof = 0, tx_want_stamp = 0, tx_last_desc = 0;
  logic [31:0] update_seconds = 0, update_subseconds = 0, addend_value = 0;
  wire logic fabric_ptp_reference_clock, hps_ref_tick, rx_stamp_valid, rx_stamp_skip;
  wire logic tx_stamp_valid, tx_stamp_skip, pps_reg;
  wire logic [63:0] system_time_reg, rx_stamp, tx_stamp;
  logic [63:0] t, q[$];
  int mismatches = 0, tests_run = 0, seed = 21648;
  pst_ref_source pst_ref_source_inst (.*);
  pst_system_time pst_system_time_inst (.*);
  initial forever #25 clock = ~clock;
  task cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task tick(input int k);
    run = 1;
    cyc(4 * k);
    run = 0;
    cyc(8);
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ns field wraps at one second in both directions
  function logic [63:0] addt(input logic [63:0] a, b, input logic s);
    logic [32:0] m;
    m = s ? a[31:0] - b[31:0] : a[31:0] + b[31:0];
    addt[63:32] = s ? a[63:32] - b[63:32] - m[32] : a[63:32] + b[63:32] + (m >= 33'h03B9ACA00);
    addt[31:0] = m[32] ? m[31:0] + 32'h3B9ACA00 : m >= 33'h03B9ACA00 ? m[31:0] - 32'h3B9ACA00 : m[31:0];
  endfunction
  task frame(input logic r, input logic w, input int len);
    if (r | w) q.push_back(system_time_reg);
    {rx_sof, tx_sof, tx_want_stamp} = {r, !r, w};
    cyc(len);
    {rx_sof, tx_sof} = 2'h0;
    cyc(1);
    {rx_last_desc, tx_last_desc} = {r, !r};
    cyc(1);
    {rx_last_desc, tx_last_desc} = 2'h0;
    cyc(9);
  endtask
  always @(negedge clock) if (rx_stamp_valid | tx_stamp_valid)
    `CHK(rx_stamp_valid ? rx_stamp : tx_stamp, q.pop_front())
  initial begin
    cyc(20);
    rst = 0;
    cyc(1);
    `CHK(system_time_reg, 64'h0)
    for (int k = 0; k < 3; k++) begin
      update_seconds = $random(seed);
      update_subseconds = $unsigned($random(seed)) % 32'h3B9ACA00;
      t = k ? addt(system_time_reg, {update_seconds, update_subseconds}, offset_subtract)
        : {update_seconds, update_subseconds};
      {init_strobe, offset_strobe} = {k == 0, k != 0};
      cyc(1);
      {init_strobe, offset_strobe} = 2'h0;
      cyc(2);
      `CHK(system_time_reg, t)
      `CHK(pps_reg, t[31:0] < 32'h1DCD6500)
      offset_subtract = !offset_subtract;
    end
    $display("coarse done");
    for (int k = 0; k < 4; k++) begin
      {pick_fabric, use_fabric_ref} = k[1:0];
      t = system_time_reg;
      tick(5);
      `CHK(system_time_reg, addt(t, pick_fabric == use_fabric_ref ? 32'hD7 : 0, 0))
    end
    $display("select done");
    fine_mode = 1;
    for (int k = 0; k < 2; k++) begin
      addend_value = 32'h80000000 >> k;
      addend_write = 1;
      cyc(1);
      addend_write = 0;
      t = system_time_reg;
      tick(8);
      `CHK(system_time_reg, addt(t, k ? 32'h56 : 32'hAC, 0))
    end
    $display("fine done");
    frame(1, 0, 1);
    frame(1, 0, 2);
    frame(0, 1, 1);
    frame(0, 0, 1);
    `CHK(q.size(), 0)
    $display("frames done");
    end_of_test;
  end
endmodule
`default_nettype wire
